// [design/nvm_map.svh]
// Offsets, codes, bit positions and address map of the NVM sequencer.
// Assumes inclusion by bare name; holds definitions only.
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// ****************************************
// Register byte offsets (low address byte)
// ****************************************
`define NVM_OFS_PROTECT 8'h00
`define NVM_OFS_ADDRESS 8'h04
`define NVM_OFS_DATA 8'h08
`define NVM_OFS_COMMAND 8'h0c
`define NVM_OFS_STATUS 8'h10
`define NVM_OFS_HI 7
`define NVM_CMD_HI 7
`define NVM_ALIGN_HI 1
`define NVM_ALIGNED 2'b00

// ****************************************
// Command codes and protect key
// ****************************************
`define NVM_CMD_PROGRAM 8'h9a
`define NVM_CMD_ERASE 8'ha6
`define NVM_KEY_HI 7
`define NVM_KEY_LO 6
`define NVM_KEY_VAL 2'b10
`define NVM_CODE_WE_BIT 3
`define NVM_DATA_WE_BIT 2

// ****************************************
// Status bit positions
// ****************************************
`define NVM_ST_TOUT 0
`define NVM_ST_CMD_ERR 1
`define NVM_ST_ADDR_OK 6
`define NVM_ST_RSV_HI 10
`define NVM_ST_RSV_LO 9
`define NVM_ST_RSV_VAL 2'b01

// ****************************************
// Array map and erase geometry
// ****************************************
`define NVM_WORDS 1536
`define NVM_IDX_HI 12
`define NVM_IDX_LO 2
`define NVM_SEC_HI 12
`define NVM_SEC_LO 9
`define NVM_SEC_ZERO 7'h00
`define NVM_SEC_LAST 7'h7f
`define NVM_SPACE_HI 31
`define NVM_SPACE_LO 13
`define NVM_SPACE_ZERO 19'h00000
`define NVM_DATA_BASE 32'h0000_1000
`define NVM_INFO_BASE 32'h0000_1400
`define NVM_ID_BASE 32'h0000_1800
`define NVM_ID_END 32'h0000_1808
`define NVM_ID_HALF_BIT 2
`define NVM_ERASED 32'hffff_ffff
`define NVM_RESP_OKAY 2'b00
`define NVM_RESP_SLVERR 2'b10

`endif

// [design/nvm_pkg.sv]
// Types of the NVM erase/program sequencer.
// Assumes nvm_map.svh supplies the numeric constants.
package nvm_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    NVM_IDLE,
    NVM_ERASE,
    NVM_PROG
  } nvm_state_t;

  // ****************************************
  // Complete module state apart from the array
  // ****************************************
  typedef struct packed {
    nvm_state_t  state;
    logic [6:0]  cnt;
    logic [10:0] op_idx;
    logic        code_we;
    logic        data_we;
    logic [31:0] addr;
    logic [31:0] data;
    logic        cmd_err;
    logic        tout;
    logic        addr_ok;
    logic        busy;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        mem_ready;
    logic [31:0] mem_rdata;
  } nvm_regs_t;

endpackage : nvm_pkg

// [design/nvm_seq.sv]
// NVM erase/program sequencer with AXI4-Lite registers and fetch port.
// Assumes one clock, synchronous reset, fetch master holding req to ready.
// How it works
// - Erase writes all ones into every word of the chosen sector.
// - Code, data, info areas need their enables; info needs both.
// - Erase takes the 32-bit address register, ignoring low bits.
// - Each erase clears one 512-byte sector, 128 words.
// - Command code a6 starts a sector erase at the loaded address.
// - Processor stays stalled during an operation, released when done.
// - Programming only clears bits; stored zeros stay zero.
// - Command code 9a programs the data word at the address.
// - Stored contents read with plain memory accesses, no command.
// - Eight read-only bytes hold the part ID and its checksum.
// - Any other command code sets the command error flag.
// - Result flag reads one on timeout, zero on success.
// - Address valid flag shows whether the address is acceptable.
// - Protect writes take effect only with key 10b in bits 7:6.
`timescale 1ns/1ns
`include "nvm_map.svh"

module nvm_seq #(
  parameter logic [31:0] NVM_ID_WORD0 = 32'h1234_5678, // Arbitrary value
  parameter logic [31:0] NVM_ID_WORD1 = 32'h0000_a5c3  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // AXI4-Lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Processor fetch port into the array
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata,
  // Operation in progress
  output logic             nvm_busy
);

  // ****************************************
  // State, array and array controls
  // ****************************************
  nvm_pkg::nvm_regs_t r_reg;
  nvm_pkg::nvm_regs_t r_next;
  logic [31:0]        mem_array [0:`NVM_WORDS-1];
  logic               mem_we;
  logic [10:0]        mem_wa;
  logic [31:0]        mem_wd;
  logic [10:0]        rd_idx;
  logic [31:0]        mem_q;
  logic [7:0]         wr_ofs;
  logic [7:0]         rd_ofs;

  // Area check: enables per area, ID and beyond never writable
  function automatic logic nvm_area_ok(input logic [31:0] a,
                                       input logic code_we,
                                       input logic data_we);
    logic ok;
    ok = 1'b0;
    if (a[`NVM_SPACE_HI:`NVM_SPACE_LO] != `NVM_SPACE_ZERO) begin
      ok = 1'b0;
    end else if (a < `NVM_DATA_BASE) begin
      ok = code_we;
    end else if (a < `NVM_INFO_BASE) begin
      ok = data_we;
    end else if (a < `NVM_ID_BASE) begin
      ok = code_we & data_we;
    end
    return ok;
  endfunction : nvm_area_ok

  // Merge a write with its byte strobes
  function automatic logic [31:0] nvm_strobe(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        v[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return v;
  endfunction : nvm_strobe

  assign wr_ofs = s_axi_awaddr[`NVM_OFS_HI:0];
  assign rd_ofs = s_axi_araddr[`NVM_OFS_HI:0];
  // Sequencer owns the read port while busy
  assign rd_idx = r_reg.busy ? r_reg.op_idx
                             : mem_addr[`NVM_IDX_HI:`NVM_IDX_LO];
  assign mem_q  = mem_array[rd_idx];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    r_next = r_reg;
    mem_we = 1'b0;
    mem_wa = r_reg.op_idx;
    mem_wd = `NVM_ERASED;
    r_next.awready   = 1'b0;
    r_next.wready    = 1'b0;
    r_next.arready   = 1'b0;
    r_next.mem_ready = 1'b0;
    // Flag follows the loaded address and enables
    r_next.addr_ok = nvm_area_ok(r_reg.addr, r_reg.code_we, r_reg.data_we)
                     && (r_reg.addr[`NVM_ALIGN_HI:0] == `NVM_ALIGNED);
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    case (r_reg.state)
      nvm_pkg::NVM_IDLE: begin
        // Register write, both channels taken together
        if (r_reg.awready && s_axi_awvalid && s_axi_wvalid) begin
          r_next.bvalid = 1'b1;
          r_next.bresp  = `NVM_RESP_OKAY;
          case (wr_ofs)
            `NVM_OFS_PROTECT: begin
              if (s_axi_wstrb[0] &&
                  s_axi_wdata[`NVM_KEY_HI:`NVM_KEY_LO] == `NVM_KEY_VAL)
              begin
                r_next.code_we = s_axi_wdata[`NVM_CODE_WE_BIT];
                r_next.data_we = s_axi_wdata[`NVM_DATA_WE_BIT];
              end
            end
            `NVM_OFS_ADDRESS: begin
              r_next.addr = nvm_strobe(r_reg.addr, s_axi_wdata,
                                       s_axi_wstrb);
            end
            `NVM_OFS_DATA: begin
              r_next.data = nvm_strobe(r_reg.data, s_axi_wdata,
                                       s_axi_wstrb);
            end
            `NVM_OFS_COMMAND: begin
              if (s_axi_wstrb[0]) begin
                r_next.cmd_err = 1'b0;
                if (s_axi_wdata[`NVM_CMD_HI:0] == `NVM_CMD_PROGRAM) begin
                  if (r_next.addr_ok) begin
                    r_next.state  = nvm_pkg::NVM_PROG;
                    r_next.busy   = 1'b1;
                    r_next.tout   = 1'b0;
                    r_next.op_idx =
                      r_reg.addr[`NVM_IDX_HI:`NVM_IDX_LO];
                  end else begin
                    r_next.tout = 1'b1;
                  end
                end else if (s_axi_wdata[`NVM_CMD_HI:0] == `NVM_CMD_ERASE) begin
                  if (nvm_area_ok(r_reg.addr, r_reg.code_we,
                                  r_reg.data_we)) begin
                    r_next.state  = nvm_pkg::NVM_ERASE;
                    r_next.busy   = 1'b1;
                    r_next.tout   = 1'b0;
                    r_next.cnt    = `NVM_SEC_ZERO;
                    r_next.op_idx = {r_reg.addr[`NVM_SEC_HI:`NVM_SEC_LO],
                                     `NVM_SEC_ZERO};
                  end else begin
                    r_next.tout = 1'b1;
                  end
                end else begin
                  r_next.cmd_err = 1'b1;
                end
              end
            end
            `NVM_OFS_STATUS: begin
              r_next.bresp = `NVM_RESP_OKAY;
            end
            default: begin
              r_next.bresp = `NVM_RESP_SLVERR;
            end
          endcase
        end else if (s_axi_awvalid && s_axi_wvalid && !r_reg.bvalid &&
                     !r_reg.awready) begin
          r_next.awready = 1'b1;
          r_next.wready  = 1'b1;
        end
        // Register read
        if (r_reg.arready && s_axi_arvalid) begin
          r_next.rvalid = 1'b1;
          r_next.rresp  = `NVM_RESP_OKAY;
          r_next.rdata  = 32'h0000_0000;
          case (rd_ofs)
            `NVM_OFS_PROTECT: begin
              r_next.rdata[`NVM_KEY_HI:`NVM_KEY_LO] = `NVM_KEY_VAL;
              r_next.rdata[`NVM_CODE_WE_BIT] = r_reg.code_we;
              r_next.rdata[`NVM_DATA_WE_BIT] = r_reg.data_we;
            end
            `NVM_OFS_ADDRESS: begin
              r_next.rdata = r_reg.addr;
            end
            `NVM_OFS_DATA: begin
              r_next.rdata = r_reg.data;
            end
            `NVM_OFS_COMMAND: begin
              r_next.rdata = 32'h0000_0000;
            end
            `NVM_OFS_STATUS: begin
              r_next.rdata[`NVM_ST_RSV_HI:`NVM_ST_RSV_LO] = `NVM_ST_RSV_VAL;
              r_next.rdata[`NVM_ST_ADDR_OK] = r_reg.addr_ok;
              r_next.rdata[`NVM_ST_CMD_ERR] = r_reg.cmd_err;
              r_next.rdata[`NVM_ST_TOUT]    = r_reg.tout;
            end
            default: begin
              r_next.rresp = `NVM_RESP_SLVERR;
            end
          endcase
        end else if (s_axi_arvalid && !r_reg.rvalid && !r_reg.arready) begin
          r_next.arready = 1'b1;
        end
        // Fetch port, answered only while idle
        if (mem_req && !r_reg.mem_ready) begin
          r_next.mem_ready = 1'b1;
          if (mem_addr >= `NVM_ID_BASE && mem_addr < `NVM_ID_END) begin
            r_next.mem_rdata = mem_addr[`NVM_ID_HALF_BIT] ?
                               NVM_ID_WORD1 : NVM_ID_WORD0;
          end else if (mem_addr < `NVM_ID_BASE) begin
            r_next.mem_rdata = mem_q;
          end else begin
            r_next.mem_rdata = 32'h0000_0000;
          end
        end
      end
      nvm_pkg::NVM_ERASE: begin
        // One word of ones per cycle across the sector
        mem_we = 1'b1;
        mem_wa = r_reg.op_idx;
        mem_wd = `NVM_ERASED;
        r_next.op_idx = r_reg.op_idx + 11'h001;
        r_next.cnt    = r_reg.cnt + 7'h01;
        if (r_reg.cnt == `NVM_SEC_LAST) begin
          r_next.state = nvm_pkg::NVM_IDLE;
          r_next.busy  = 1'b0;
        end
      end
      nvm_pkg::NVM_PROG: begin
        // Only ones may turn into zeros
        mem_we = 1'b1;
        mem_wa = r_reg.op_idx;
        mem_wd = mem_q & r_reg.data;
        r_next.state = nvm_pkg::NVM_IDLE;
        r_next.busy  = 1'b0;
      end
      default: begin
        r_next.state = nvm_pkg::NVM_IDLE;
        r_next.busy  = 1'b0;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Array write port, contents survive reset
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem_array[mem_wa] <= mem_wd;
    end
  end

  // ****************************************
  // Outputs straight from the state register
  // ****************************************
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready  = r_reg.wready;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;
  assign mem_ready     = r_reg.mem_ready;
  assign mem_rdata     = r_reg.mem_rdata;
  assign nvm_busy      = r_reg.busy;

endmodule : nvm_seq

// [sim/nvm_cpu_model.sv]
// Processor fetch side of the NVM sequencer.
// Assumes the sequencer answers each held request with one ready pulse.
`timescale 1ns/1ns
module nvm_cpu_model (
  // Clock
  input  wire logic        clk_sys,
  // Fetch answer
  input  wire logic        mem_ready,
  input  wire logic [31:0] mem_rdata,
  // Fetch request
  output logic             mem_req,
  output logic [31:0]      mem_addr
);
  // Idle bus at time zero
  initial begin
    mem_req = 1'b0;
    mem_addr = 32'h0000_0000;
  end

  // Plain load, held until ready, address inverted once released
  task automatic fetch(input logic [31:0] a, output logic [31:0] d,
                       output int n);
    bit got;
    got = 1'b0;
    @(posedge clk_sys);
    mem_req <= 1'b1;
    mem_addr <= a;
    n = 0;
    // Edges without ready; 400 means the wait ran out
    while (n < 400 && !got) begin
      @(posedge clk_sys);
      got = (mem_ready === 1'b1);
      if (!got) n++;
    end
    d = mem_rdata;
    mem_req <= 1'b0;
    mem_addr <= ~a;
  endtask : fetch
endmodule : nvm_cpu_model

// [sim/nvm_seq_checker.sv]
// Port checker of the NVM sequencer.
// Assumes binding into nvm_seq; sees only its ports.
`timescale 1ns/1ns
module nvm_seq_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Fetch and busy
  input wire logic        mem_req,
  input wire logic        mem_ready,
  input wire logic        nvm_busy
);
  logic [7:0] busy_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Length of the running busy period
  always_ff @(posedge clk_sys) begin
    if (reset) busy_cnt <= 8'h00;
    else busy_cnt <= nvm_busy ? busy_cnt + 8'h01 : 8'h00;
  end

  a_stall_fetch: assert property (nvm_busy |-> !mem_ready)
    else $error("fetch answered while busy");
  a_stall_bus: assert property (nvm_busy |->
    !s_axi_awready && !s_axi_arready)
    else $error("bus taken while busy");
  a_busy_len: assert property ($fell(nvm_busy) |->
    busy_cnt == 8'h01 || busy_cnt == 8'h80)
    else $error("busy period of wrong length");
  a_fetch_done: assert property (mem_req && !mem_ready |->
    ##[1:140] mem_ready)
    else $error("fetch never released");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_resp: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  a_ready_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready apart");
endmodule : nvm_seq_checker

bind nvm_seq nvm_seq_checker u_chk (.clk_sys(clk_sys), .reset(reset),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .mem_req(mem_req), .mem_ready(mem_ready),
  .nvm_busy(nvm_busy));

// [sim/testbench.sv]
// Self-checking bench of the NVM sequencer.
// Assumes nvm_seq, its bound checker and nvm_cpu_model are compiled.
`timescale 1ns/1ns
module testbench;
  localparam logic [31:0] ID0 = 32'h0bad_f00d; // Arbitrary value
  localparam logic [31:0] ID1 = 32'h0000_7e11; // Arbitrary value
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic awr, wrdy, bv, arr, rv, mreq, mrdy, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] awaddr = 32'h0, araddr = 32'h0, wdata = 32'h0;
  logic [31:0] rdata, maddr, mrd;
  int mismatches = 0;
  int compares = 0;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  nvm_seq #(.NVM_ID_WORD0(ID0), .NVM_ID_WORD1(ID1)) dut (
    .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .mem_req(mreq), .mem_addr(maddr),
    .mem_ready(mrdy), .mem_rdata(mrd), .nvm_busy(busy));

  nvm_cpu_model u_cpu (.clk_sys(clk_sys), .mem_ready(mrdy),
    .mem_rdata(mrd), .mem_req(mreq), .mem_addr(maddr));

  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic hang();
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    final_report();
  endtask : hang

  // Write; response ready raised one edge after both are taken
  task automatic bw(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = 2'b00);
    bit got;
    got = 1'b0;
    @(posedge clk_sys);
    awv <= 1'b1;
    wv <= 1'b1;
    awaddr <= {24'h000000, a};
    wdata <= d;
    for (int n = 0; n < 400 && !got; n++) begin
      @(posedge clk_sys);
      if (brdy === 1'b1 && bv === 1'b1) begin
        got = 1'b1;
        brdy <= 1'b0;
        chk({30'h0, bresp}, {30'h0, e});
      end
      else if (awv === 1'b0 && wv === 1'b0) brdy <= 1'b1;
      if (awv === 1'b1 && awr === 1'b1) awv <= 1'b0;
      if (wv === 1'b1 && wrdy === 1'b1) wv <= 1'b0;
    end
    if (!got) hang();
  endtask : bw

  // Read with masked data compare
  task automatic br(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff,
                    input logic [1:0] r = 2'b00);
    bit got;
    got = 1'b0;
    @(posedge clk_sys);
    arv <= 1'b1;
    araddr <= {24'h000000, a};
    for (int n = 0; n < 400 && !got; n++) begin
      @(posedge clk_sys);
      if (rrdy === 1'b1 && rv === 1'b1) begin
        got = 1'b1;
        rrdy <= 1'b0;
        chk(rdata & m, e);
        chk({30'h0, rresp}, {30'h0, r});
      end
      else if (arv === 1'b0) rrdy <= 1'b1;
      if (arv === 1'b1 && arr === 1'b1) arv <= 1'b0;
    end
    if (!got) hang();
  endtask : br

  task automatic fx(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    int n;
    u_cpu.fetch(a, d, n);
    if (n >= 400) hang();
    else chk(d, e);
  endtask : fx

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    br(8'h10, 32'h0000_0200);
    br(8'h00, 32'h0000_0080);
    br(8'h14, 32'h0, 32'hffff_ffff, 2'b10);
    bw(8'h14, 32'hffff_ffff, 2'b10);
    bw(8'h00, 32'h0000_000c);
    br(8'h00, 32'h0000_0080);
    bw(8'h00, 32'h0000_008c);
    br(8'h00, 32'h0000_008c);
  endtask : t_regs

  task automatic t_erase();
    logic [31:0] d;
    int n;
    bw(8'h04, 32'h0000_0104);
    br(8'h10, 32'h0000_0240);
    bw(8'h0c, 32'h0000_00a6);
    chk({31'h0, busy}, 32'h1);
    u_cpu.fetch(32'h0, d, n);
    if (n >= 400) hang();
    else chk(d, 32'hffff_ffff);
    chk({31'h0, n > 100}, 32'h1);
    fx(32'h0000_01fc, 32'hffff_ffff);
    br(8'h10, 32'h0000_0240);
    bw(8'h04, 32'h0000_0200);
    bw(8'h0c, 32'h0000_00a6);
    fx(32'h0000_03fc, 32'hffff_ffff);
  endtask : t_erase

  task automatic t_prog();
    bw(8'h04, 32'h0000_0008);
    bw(8'h08, 32'ha5a5_0f0f);
    bw(8'h0c, 32'h0000_009a);
    fx(32'h0000_0008, 32'ha5a5_0f0f);
    bw(8'h08, 32'hffff_00ff);
    bw(8'h0c, 32'h0000_009a);
    fx(32'h0000_0008, 32'ha5a5_000f);
    fx(32'h0000_0004, 32'hffff_ffff);
    br(8'h10, 32'h0000_0240);
  endtask : t_prog

  task automatic t_refuse();
    bw(8'h00, 32'h0000_0084);
    bw(8'h04, 32'h0000_0000);
    br(8'h10, 32'h0000_0200);
    bw(8'h0c, 32'h0000_00a6);
    br(8'h10, 32'h0000_0201);
    fx(32'h0000_0008, 32'ha5a5_000f);
    bw(8'h00, 32'h0000_0088);
    bw(8'h04, 32'h0000_1400);
    bw(8'h0c, 32'h0000_009a);
    br(8'h10, 32'h0000_0201);
  endtask : t_refuse

  task automatic t_cmd();
    bw(8'h0c, 32'h0000_0055);
    br(8'h10, 32'h0000_0002, 32'h0000_0002);
    bw(8'h00, 32'h0000_008c);
    bw(8'h04, 32'h0000_0000);
    bw(8'h08, 32'hffff_ffff);
    bw(8'h0c, 32'h0000_009a);
    br(8'h10, 32'h0000_0240);
  endtask : t_cmd

  task automatic t_ident();
    fx(32'h0000_1800, ID0);
    fx(32'h0000_1804, ID1);
    bw(8'h04, 32'h0000_1800);
    bw(8'h0c, 32'h0000_009a);
    br(8'h10, 32'h0000_0001, 32'h0000_0001);
    fx(32'h0000_1800, ID0);
    bw(8'h00, 32'h0000_0080);
    br(8'h00, 32'h0000_0080);
  endtask : t_ident

  // Reset for 4 cycles, then the scenarios
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_erase();
    t_prog();
    t_refuse();
    t_cmd();
    t_ident();
    final_report();
  end
endmodule : testbench
